// file: rtl/serial_defines.svh
// Constants of the asynchronous serial control block and its remote end.
// Behaviour
// [RULE_01] Loop select feeds transmitter output into receiver.
// [RULE_02] Module enable runs block; clearing sets transmit flags.
// [RULE_03] Transmit invert flips every driven output level.
// [RULE_04] Length select picks 9-bit or 8-bit characters.
// [RULE_05] One start, one stop; 10 or 11 bits.
// [RULE_06] Resume condition: address mark or idle line.
// [RULE_07] Idle ones count after stop or start bit.
// [RULE_08] Parity enable puts parity in top bit.
// [RULE_09] Parity type: odd when set, even when clear.
// [RULE_10] Software keeps parity type steady during characters.
// [RULE_11] Transmit enables gate empty and done flags.
// [RULE_12] Receive enables gate full and idle flags.
// [RULE_13] Transmit enable rise sends a preamble of ones.
// [RULE_14] Transmit disable finishes character, then idles high.
// [RULE_15] Clear-then-set transmit enable queues an idle character.
// [RULE_16] Software leaves enables alone while module disabled.
// [RULE_17] Receive enable gates receiver, flags stay untouched.
// [RULE_18] Standby blocks receiver interrupts; wake clears it.
// [RULE_19] Send break: breaks back to back, then one.
// [RULE_20] Software avoids toggling break right after empty.
// [RULE_21] Ninth bits travel with the data byte.
// [RULE_22] Overrun and noise enables gate error request.
// [RULE_23] Framing and parity enables gate error request.
// [RULE_24] Controls reset to zero; error enables ORed.
`ifndef SERIAL_DEFINES_SVH
`define SERIAL_DEFINES_SVH

// Clock and bit timing; the bit time rounds down to whole cycles.
`define CLK_HZ         25000000
`define BAUD_RATE      9600
`define BIT_CYCLES     (`CLK_HZ / `BAUD_RATE)
`define FRAME_SHORT    4'hA
`define FRAME_LONG     4'hB

// Register indexes on the software port.
`define REG_LINE       3'h0
`define REG_XFER       3'h1
`define REG_NINTH      3'h2
`define REG_STATUS     3'h3
`define REG_DATA       3'h4

// Field positions of line_format_control.
`define LF_LOOP        7
`define LF_EN          6
`define LF_INV         5
`define LF_LEN9        4
`define LF_WAKE        3
`define LF_IDLESTOP    2
`define LF_PAREN       1
`define LF_PARODD      0

// Field positions of transfer_control.
`define XC_TEIE        7
`define XC_TDIE        6
`define XC_RFIE        5
`define XC_IDIE        4
`define XC_TXEN        3
`define XC_RXEN        2
`define XC_SBY         1
`define XC_SBK         0

// Field positions of ninth_bit_error_control; enables sit in bits 3..0.
`define NB_RX8         7
`define NB_TX8         6

// Field positions of the status register.
`define ST_TXE         7
`define ST_TXD         6
`define ST_RXF         5
`define ST_IDLE        4
`define ST_OVR         3
`define ST_NOISE       2
`define ST_FRAME       1
`define ST_PAR         0
`define ST_RX_MASK     8'h3F

`endif

// file: rtl/serial_device.sv
// Device end: control registers, transmitter and receiver of the serial block.
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "serial_defines.svh"
module serial_device #(
    parameter int BIT_CYCLES = `BIT_CYCLES
) (
    // Clock and reset.
    input  wire  logic               clk_sys,
    input  wire  logic               rst_n,
    // Software register port.
    input  wire  serial_pkg::addr_t  addr,
    input  wire  serial_pkg::byte_t  wdata,
    input  wire  logic               wr,
    input  wire  logic               rd,
    output var   serial_pkg::byte_t  rdata,
    // Interrupt requests.
    output logic                     txIrq,
    output logic                     rxIrq,
    output logic                     errIrq,
    // Serial link.
    serial_link_if.device            link
);
    import serial_pkg::*;

    localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
    localparam logic [15:0] BIT_HALF = 16'(BIT_CYCLES / 2);

    dev_state_s s;
    dev_state_s next_s;

    // Builds a transmit frame, start bit in bit 0.
    function automatic logic [10:0] frameBits(byte_t d, logic t8, logic len9, logic parEn, logic parOdd);
        char_t c;
        c = {t8, d};
        if (!len9)
        begin
            c[8] = 1'b1;
        end
        if (parEn && len9)
        begin
            c[8] = (^d) ^ parOdd; // see [RULE_08] see [RULE_09]
        end
        else if (parEn)
        begin
            c[7] = (^d[6:0]) ^ parOdd; // see [RULE_08] see [RULE_09]
        end
        return {1'b1, c, 1'b0}; // see [RULE_05] see [RULE_21]
    endfunction

    // Next-state logic of the whole block.
    always_comb
    begin
        logic        en;
        logic        len9;
        logic [3:0]  frameLen;
        logic        canStart;
        logic        ld;
        logic [10:0] ldShift;
        logic [3:0]  ldCnt;
        logic        rxIn;
        logic        sample;
        logic [10:0] fr;
        logic        msb;
        logic        idleHit;
        en = s.lineCtl[`LF_EN];
        len9 = s.lineCtl[`LF_LEN9];
        frameLen = len9 ? `FRAME_LONG : `FRAME_SHORT; // see [RULE_04] see [RULE_05]
        ld = 1'b0;
        ldShift = '1;
        ldCnt = frameLen;
        rxIn = s.lineCtl[`LF_LOOP] ? s.txd : s.rxSync2; // see [RULE_01]
        sample = 1'b0;
        fr = '0;
        msb = 1'b0;
        idleHit = 1'b0;
        canStart = (s.txState == TX_IDLE) || (s.txTimer == '0 && s.txBits == '0);
        next_s = s;
        next_s.rdata = '0;
        next_s.rxSync1 = link.remTx;
        next_s.rxSync2 = s.rxSync1;

        // Register writes; enables stay put while the module is off.
        if (wr)
        begin
            unique case (addr)
                `REG_LINE:  next_s.lineCtl = wdata;
                `REG_XFER:
                begin
                    next_s.xferCtl = wdata;
                    if (!en)
                    begin
                        next_s.xferCtl[`XC_TXEN] = s.xferCtl[`XC_TXEN]; // see [RULE_16]
                        next_s.xferCtl[`XC_RXEN] = s.xferCtl[`XC_RXEN]; // see [RULE_16]
                    end
                end
                `REG_NINTH:
                begin
                    next_s.tx8 = wdata[`NB_TX8];
                    next_s.errIe = wdata[3:0];
                end
                `REG_DATA:
                begin
                    next_s.dataTx = wdata;
                    next_s.status[`ST_TXE] = 1'b0;
                end
                default: ;
            endcase
        end

        // Register reads; status read arms the two-step flag clear.
        if (rd)
        begin
            unique case (addr)
                `REG_LINE:   next_s.rdata = s.lineCtl;
                `REG_XFER:   next_s.rdata = s.xferCtl;
                `REG_NINTH:  next_s.rdata = {s.rx8, s.tx8, 2'b00, s.errIe};
                `REG_STATUS:
                begin
                    next_s.rdata = s.status;
                    next_s.seen = s.status & `ST_RX_MASK;
                end
                `REG_DATA:
                begin
                    next_s.rdata = s.dataRx;
                    next_s.status = s.status & ~s.seen;
                    next_s.seen = '0;
                end
                default: next_s.rdata = '0;
            endcase
        end

        // A rising transmit enable queues a preamble or idle character.
        next_s.oldTxEn = s.xferCtl[`XC_TXEN];
        if (s.xferCtl[`XC_TXEN] && !s.oldTxEn)
        begin
            next_s.pendIdle = 1'b1; // see [RULE_13] see [RULE_15]
        end

        // Transmit shifter; a new frame may follow the last bit directly.
        if (s.txState == TX_SHIFT && s.txTimer != '0)
        begin
            next_s.txTimer = s.txTimer - 16'h0001;
        end
        else if (s.txState == TX_SHIFT && s.txBits != '0)
        begin
            next_s.txLine = s.txShift[0];
            next_s.txShift = {1'b1, s.txShift[10:1]};
            next_s.txBits = s.txBits - 4'h1;
            next_s.txTimer = BIT_LAST;
        end
        if (canStart)
        begin
            next_s.txState = TX_IDLE;
            next_s.txLine = 1'b1; // see [RULE_14]
            if (s.xferCtl[`XC_TXEN] && s.xferCtl[`XC_SBK])
            begin
                ld = 1'b1;
                ldShift = '0; // see [RULE_19]
                next_s.brkTail = 1'b1;
                next_s.pendIdle = 1'b0;
            end
            else if (s.brkTail)
            begin
                ld = 1'b1;
                ldCnt = 4'h1; // see [RULE_19]
                next_s.brkTail = 1'b0;
            end
            else if (s.xferCtl[`XC_TXEN] && s.pendIdle)
            begin
                ld = 1'b1; // see [RULE_13] see [RULE_15]
                next_s.pendIdle = 1'b0;
            end
            else if (s.xferCtl[`XC_TXEN] && !s.status[`ST_TXE])
            begin
                ld = 1'b1;
                ldShift = frameBits(s.dataTx, s.tx8, len9, s.lineCtl[`LF_PAREN], s.lineCtl[`LF_PARODD]);
                next_s.status[`ST_TXE] = 1'b1;
            end
        end
        if (ld)
        begin
            next_s.txState = TX_SHIFT;
            next_s.txLine = ldShift[0];
            next_s.txShift = {1'b1, ldShift[10:1]};
            next_s.txBits = ldCnt - 4'h1;
            next_s.txTimer = BIT_LAST;
        end

        // Receiver: hunt for a start bit, then sample each bit mid-way.
        if (!(en && s.xferCtl[`XC_RXEN]))
        begin
            next_s.rxState = RX_HUNT; // see [RULE_17]
            next_s.ones = '0;
        end
        else if (s.rxTimer != '0)
        begin
            next_s.rxTimer = s.rxTimer - 16'h0001;
            if (s.rxState == RX_HUNT && !rxIn)
            begin
                next_s.rxState = RX_RUN;
                next_s.rxTimer = BIT_HALF;
                next_s.rxBits = frameLen;
            end
        end
        else
        begin
            sample = 1'b1;
            next_s.rxTimer = BIT_LAST;
            if (s.rxState == RX_HUNT && !rxIn)
            begin
                next_s.rxState = RX_RUN;
                next_s.rxTimer = BIT_HALF;
                next_s.rxBits = frameLen;
            end
        end

        // Idle counting of ones, inside the frame only when counting after the start bit.
        if (sample && (s.rxState == RX_HUNT || !s.lineCtl[`LF_IDLESTOP]) && rxIn) // see [RULE_07]
        begin
            next_s.ones = (s.ones == 4'hF) ? s.ones : s.ones + 4'h1;
            idleHit = (s.ones + 4'h1 == frameLen);
        end
        else if (sample)
        begin
            next_s.ones = '0;
        end

        // Sampled bits of a running frame, with the stop bit closing it.
        if (sample && s.rxState == RX_RUN)
        begin
            next_s.rxShift = {rxIn, s.rxShift[10:1]};
            next_s.rxBits = s.rxBits - 4'h1;
            if (s.rxBits == frameLen && rxIn)
            begin
                next_s.rxState = RX_HUNT;
                next_s.status[`ST_NOISE] = 1'b1;
            end
            else if (s.rxBits == 4'h1)
            begin
                next_s.rxState = RX_HUNT;
                fr = len9 ? next_s.rxShift : {1'b0, next_s.rxShift[10:1]};
                msb = len9 ? fr[9] : fr[8];
                if (s.xferCtl[`XC_SBY] && s.lineCtl[`LF_WAKE] && msb)
                begin
                    next_s.xferCtl[`XC_SBY] = 1'b0; // see [RULE_06] see [RULE_18]
                end
                if (!s.xferCtl[`XC_SBY] || (s.lineCtl[`LF_WAKE] && msb))
                begin
                    if (s.status[`ST_RXF])
                    begin
                        next_s.status[`ST_OVR] = 1'b1;
                    end
                    else
                    begin
                        next_s.dataRx = fr[8:1];
                        next_s.rx8 = len9 ? fr[9] : fr[8]; // see [RULE_21]
                        next_s.status[`ST_RXF] = 1'b1;
                        next_s.idleArmed = 1'b1;
                        if (!(len9 ? fr[10] : fr[9]))
                        begin
                            next_s.status[`ST_FRAME] = 1'b1;
                        end
                        if (s.lineCtl[`LF_PAREN] && ((len9 ? ^fr[9:1] : ^fr[8:1]) != s.lineCtl[`LF_PARODD]))
                        begin
                            next_s.status[`ST_PAR] = 1'b1; // see [RULE_08] see [RULE_09]
                        end
                    end
                end
            end
        end

        // An idle character either wakes the receiver or raises the idle flag.
        if (idleHit && s.xferCtl[`XC_SBY] && !s.lineCtl[`LF_WAKE])
        begin
            next_s.xferCtl[`XC_SBY] = 1'b0; // see [RULE_06] see [RULE_18]
        end
        else if (idleHit && s.idleArmed && !s.xferCtl[`XC_SBY])
        begin
            next_s.status[`ST_IDLE] = 1'b1;
            next_s.idleArmed = 1'b0;
        end

        // A disabled module parks the transmitter and reports it empty.
        if (!en)
        begin
            next_s.status[`ST_TXE] = 1'b1; // see [RULE_02]
            next_s.txState = TX_IDLE;
            next_s.txLine = 1'b1;
            next_s.pendIdle = 1'b0;
            next_s.brkTail = 1'b0;
        end
        next_s.status[`ST_TXD] = next_s.status[`ST_TXE] && next_s.txState == TX_IDLE
                                 && !next_s.pendIdle && !next_s.brkTail; // see [RULE_02]
        next_s.txd = next_s.txLine ^ next_s.lineCtl[`LF_INV]; // see [RULE_03]

        // Interrupt requests from flags and their enables.
        next_s.txIrq = next_s.lineCtl[`LF_EN]
                       && ((next_s.status[`ST_TXE] && next_s.xferCtl[`XC_TEIE])
                       || (next_s.status[`ST_TXD] && next_s.xferCtl[`XC_TDIE])); // see [RULE_02] see [RULE_11]
        next_s.rxIrq = !next_s.xferCtl[`XC_SBY]
                       && ((next_s.status[`ST_RXF] && next_s.xferCtl[`XC_RFIE])
                       || (next_s.status[`ST_IDLE] && next_s.xferCtl[`XC_IDIE])); // see [RULE_12] see [RULE_18]
        next_s.errIrq = |(next_s.status[3:0] & next_s.errIe); // see [RULE_22] see [RULE_23] see [RULE_24]
    end

    // State register; controls clear, transmit flags and line levels set.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0; // see [RULE_24]
            s.status <= 8'hC0;
            s.txState <= TX_IDLE;
            s.rxState <= RX_HUNT;
            s.txLine <= 1'b1;
            s.txd <= 1'b1;
            s.rxSync1 <= 1'b1;
            s.rxSync2 <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register.
    assign rdata = s.rdata;
    assign txIrq = s.txIrq;
    assign rxIrq = s.rxIrq;
    assign errIrq = s.errIrq;
    assign link.devTx = s.txd;
endmodule

// file: rtl/serial_link_if.sv
// Two-wire serial link between the device and the remote end.
`timescale 1ns/10ps
interface serial_link_if;
    logic devTx;
    logic remTx;

    // Device drives its transmit wire and listens on the remote one.
    modport device (output devTx, input remTx);
    modport remote (input devTx, output remTx);
endinterface

// file: rtl/serial_pkg.sv
// Types shared by both ends of the serial link.
package serial_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [2:0] addr_t;
    typedef logic [8:0] char_t;

    typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} tx_state_e;
    typedef enum logic [1:0] {RX_HUNT = 2'b01, RX_RUN = 2'b10} rx_state_e;

    typedef struct packed {
        byte_t       lineCtl;
        byte_t       xferCtl;
        logic        rx8;
        logic        tx8;
        logic [3:0]  errIe;
        byte_t       status;
        byte_t       seen;
        byte_t       dataRx;
        byte_t       dataTx;
        byte_t       rdata;
        tx_state_e   txState;
        logic [10:0] txShift;
        logic [3:0]  txBits;
        logic [15:0] txTimer;
        logic        txLine;
        logic        pendIdle;
        logic        brkTail;
        logic        oldTxEn;
        logic        rxSync1;
        logic        rxSync2;
        rx_state_e   rxState;
        logic [15:0] rxTimer;
        logic [3:0]  rxBits;
        logic [10:0] rxShift;
        logic [3:0]  ones;
        logic        idleArmed;
        logic        txIrq;
        logic        rxIrq;
        logic        errIrq;
        logic        txd;
    } dev_state_s;

    typedef struct packed {
        tx_state_e   txState;
        logic [10:0] txShift;
        logic [3:0]  txBits;
        logic [15:0] txTimer;
        logic        txd;
        logic        ready;
        logic        sync1;
        logic        sync2;
        rx_state_e   rxState;
        logic [15:0] rxTimer;
        logic [3:0]  rxBits;
        logic [10:0] rxShift;
        char_t       recvData;
        logic        recvValid;
        logic        recvFramingErr;
    } rem_state_s;
endpackage

// file: rtl/serial_remote.sv
// Remote end: plain asynchronous transmitter and receiver on the link.
`timescale 1ns/10ps
`include "serial_defines.svh"
module serial_remote #(
    parameter int BIT_CYCLES = `BIT_CYCLES
) (
    // Clock and reset.
    input  wire  logic               clk_sys,
    input  wire  logic               rst_n,
    // Character format.
    input  wire  logic               nineBit,
    // Send side.
    input  wire  serial_pkg::char_t  sendData,
    input  wire  logic               sendValid,
    output logic                     sendReady,
    // Receive side.
    output var   serial_pkg::char_t  recvData,
    output logic                     recvValid,
    output logic                     recvFramingErr,
    // Serial link.
    serial_link_if.remote            link
);
    import serial_pkg::*;

    localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
    localparam logic [15:0] BIT_HALF = 16'(BIT_CYCLES / 2);

    rem_state_s s;
    rem_state_s next_s;

    // Next-state logic of transmitter and receiver.
    always_comb
    begin
        logic [3:0]  frameLen;
        logic [10:0] fr;
        frameLen = nineBit ? `FRAME_LONG : `FRAME_SHORT; // see [RULE_05]
        fr = '0;
        next_s = s;
        next_s.recvValid = 1'b0;
        next_s.sync1 = link.devTx;
        next_s.sync2 = s.sync1;

        // Transmitter: start bit, data, ninth bit if nine-bit, stop.
        if (s.txState == TX_SHIFT && s.txTimer != '0)
        begin
            next_s.txTimer = s.txTimer - 16'h0001;
        end
        else if (s.txState == TX_SHIFT && s.txBits != '0)
        begin
            next_s.txd = s.txShift[0];
            next_s.txShift = {1'b1, s.txShift[10:1]};
            next_s.txBits = s.txBits - 4'h1;
            next_s.txTimer = BIT_LAST;
        end
        else if (s.txState == TX_SHIFT)
        begin
            next_s.txState = TX_IDLE;
            next_s.txd = 1'b1;
        end
        else if (sendValid && s.ready)
        begin
            next_s.txState = TX_SHIFT;
            next_s.txd = 1'b0;
            next_s.txShift = {2'b11, (nineBit ? sendData[8] : 1'b1), sendData[7:0]}; // see [RULE_21]
            next_s.txBits = frameLen - 4'h1;
            next_s.txTimer = BIT_LAST;
        end
        next_s.ready = (next_s.txState == TX_IDLE) && !(sendValid && s.ready);

        // Receiver: mid-bit sampling of the synchronised device output.
        if (s.rxState == RX_HUNT)
        begin
            if (!s.sync2)
            begin
                next_s.rxState = RX_RUN;
                next_s.rxTimer = BIT_HALF;
                next_s.rxBits = frameLen;
            end
        end
        else if (s.rxTimer != '0)
        begin
            next_s.rxTimer = s.rxTimer - 16'h0001;
        end
        else
        begin
            next_s.rxTimer = BIT_LAST;
            next_s.rxShift = {s.sync2, s.rxShift[10:1]};
            next_s.rxBits = s.rxBits - 4'h1;
            if (s.rxBits == frameLen && s.sync2)
            begin
                next_s.rxState = RX_HUNT;
            end
            else if (s.rxBits == 4'h1)
            begin
                next_s.rxState = RX_HUNT;
                fr = nineBit ? next_s.rxShift : {1'b0, next_s.rxShift[10:1]};
                next_s.recvData = nineBit ? fr[9:1] : {fr[8], fr[8:1]};
                next_s.recvFramingErr = !(nineBit ? fr[10] : fr[9]);
                next_s.recvValid = 1'b1;
            end
        end
    end

    // State register; the line idles high.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
            s.txState <= TX_IDLE;
            s.rxState <= RX_HUNT;
            s.txd <= 1'b1;
            s.ready <= 1'b1;
            s.sync1 <= 1'b1;
            s.sync2 <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register.
    assign sendReady = s.ready;
    assign recvData = s.recvData;
    assign recvValid = s.recvValid;
    assign recvFramingErr = s.recvFramingErr;
    assign link.remTx = s.txd;
endmodule

// file: tb/async_serial_control_regs_bench.sv
// Self-checking bench of both ends.
`timescale 1ns/10ps
`include "serial_defines.svh"
module async_serial_control_regs_bench;
    import serial_pkg::*;
    localparam int BC = 8;
    logic  clk_sys = 1'b0;
    logic  rst_n = 1'b0;
    logic  wr = 1'b0;
    logic  rd = 1'b0;
    logic  sendValid = 1'b0;
    addr_t addr = 3'h0;
    byte_t wdata = 8'h00;
    char_t sendData = 9'h000;
    byte_t rdata;
    char_t recvData;
    logic  txIrq, rxIrq, errIrq, sendReady, recvValid, recvFramingErr;
    int    n_fail = 0;
    int    n_checks = 0;
    // Both ends, the link and the checker.
    serial_link_if serial_link_if_i ();
    serial_device #(.BIT_CYCLES(BC)) serial_device_i (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .txIrq(txIrq), .rxIrq(rxIrq), .errIrq(errIrq), .link(serial_link_if_i));
    serial_remote #(.BIT_CYCLES(BC)) serial_remote_i (.clk_sys(clk_sys), .rst_n(rst_n), .nineBit(1'b0),
        .sendData(sendData), .sendValid(sendValid), .sendReady(sendReady), .recvData(recvData),
        .recvValid(recvValid), .recvFramingErr(recvFramingErr), .link(serial_link_if_i));
    serial_link_monitor serial_link_monitor_i (.clk_sys(clk_sys), .rst_n(rst_n), .devTx(serial_link_if_i.devTx),
        .remTx(serial_link_if_i.remTx), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .txIrq(txIrq), .rxIrq(rxIrq), .errIrq(errIrq));
    // Clock of 40 ns.
    initial forever #20 clk_sys = ~clk_sys;
    // Helpers for timing, bus cycles and comparison.
    task automatic tick;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic cmp(input logic [10:0] got, input logic [10:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic wait_hi(ref logic s);
        for (int i = 0; i < 3000 && s !== 1'b1; i++)
            tick();
        if (s !== 1'b1)
        begin
            n_fail++;
            give_verdict();
        end
    endtask
    task automatic wr_reg(input addr_t a, input byte_t d);
        @(posedge clk_sys);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input addr_t a, output byte_t v);
        @(posedge clk_sys);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic rd_chk(input addr_t a, input byte_t e);
        byte_t v;
        rd_reg(a, v);
        cmp(v, e);
    endtask
    // Reset values, the unmapped place and the refused enables.
    task automatic t_reset;
        rd_chk(`REG_LINE, 8'h00);
        rd_chk(`REG_NINTH, 8'h00);
        rd_chk(`REG_STATUS, 8'hC0);
        rd_chk(3'h5, 8'h00);
        wr_reg(`REG_XFER, 8'h0C);
        rd_chk(`REG_XFER, 8'h00);
        wr_reg(`REG_LINE, 8'h40);
        rd_chk(`REG_LINE, 8'h40);
    endtask
    // Preamble, then one byte to the remote end.
    task automatic t_send;
        int c;
        wr_reg(`REG_XFER, 8'h8C);
        tick();
        cmp(txIrq, 1'b1);
        wr_reg(`REG_XFER, 8'h0C);
        wr_reg(`REG_DATA, 8'hA5);
        for (c = 0; c < 300 && serial_link_if_i.devTx !== 1'b0; c++)
            tick();
        cmp(c >= 70 && c <= 80, 1'b1);
        wait_hi(recvValid);
        cmp({sendReady, recvFramingErr, recvData}, 11'h5A5);
    endtask
    // One byte from the remote end raises and clears the receive request.
    task automatic t_recv;
        byte_t v;
        wr_reg(`REG_XFER, 8'h2C);
        @(posedge clk_sys);
        sendData <= 9'h03C;
        sendValid <= 1'b1;
        @(posedge clk_sys);
        sendValid <= 1'b0;
        wait_hi(rxIrq);
        rd_reg(`REG_STATUS, v);
        cmp(v & 8'h20, 8'h20);
        rd_chk(`REG_DATA, 8'h3C);
        tick();
        cmp(rxIrq, 1'b0);
        wr_reg(`REG_XFER, 8'h0C);
    endtask
    // Inverted idle level, loopback and the ninth-bit register.
    task automatic t_line;
        byte_t v = 8'h00;
        wr_reg(`REG_LINE, 8'h60);
        repeat (BC) tick();
        cmp(serial_link_if_i.devTx, 1'b0);
        wr_reg(`REG_LINE, 8'hC0);
        repeat (3 * BC) tick();
        wr_reg(`REG_DATA, 8'h5A);
        for (int i = 0; i < 200 && v[5] !== 1'b1; i++)
            rd_reg(`REG_STATUS, v);
        rd_chk(`REG_DATA, 8'h5A);
        wr_reg(`REG_NINTH, 8'hCF);
        rd_chk(`REG_NINTH, 8'h4F);
        wr_reg(`REG_NINTH, 8'h40);
        rd_chk(`REG_NINTH, 8'h40);
    endtask
    // Reset for eight clocks, then the scenarios.
    initial
    begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_send();
        t_recv();
        t_line();
        give_verdict();
    end
endmodule

// file: tb/serial_link_monitor.sv
// Checker of the link wires and register port.
`timescale 1ns/10ps
`include "serial_defines.svh"
module serial_link_monitor (
    // Clock and reset.
    input wire logic              clk_sys,
    input wire logic              rst_n,
    // Link wires.
    input wire logic              devTx,
    input wire logic              remTx,
    // Register port and requests.
    input wire serial_pkg::addr_t addr,
    input wire serial_pkg::byte_t wdata,
    input wire logic              wr,
    input wire logic              rd,
    input wire serial_pkg::byte_t rdata,
    input wire logic              txIrq,
    input wire logic              rxIrq,
    input wire logic              errIrq
);
    import serial_pkg::*;
    // One clock domain; reset disables every property.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // Wires idle high and requests stay low as reset ends.
    AST_RST_IDLE: assert property (!$past(rst_n) |-> devTx && remTx)
        else $error("Wire not idle after reset");
    AST_IRQ_RST: assert property (!$past(rst_n) |-> !(txIrq || rxIrq || errIrq))
        else $error("Request high after reset");
    // Every bit holds for eight clocks on both wires.
    AST_DEV_HOLD: assert property ($changed(devTx) |=> $stable(devTx) [*7])
        else $error("Device bit too short");
    AST_REM_HOLD: assert property ($changed(remTx) |=> $stable(remTx) [*7])
        else $error("Remote bit too short");
    // The line register reads back what was written.
    AST_LINE_RW: assert property (
        wr && addr == `REG_LINE ##2 rd && addr == `REG_LINE |=> rdata == $past(wdata, 3))
        else $error("Line register read back wrong");
    // Cleared enables keep their request low.
    AST_TX_OFF: assert property (wr && addr == `REG_XFER && wdata[7:6] == 2'b00 |-> ##2 !txIrq)
        else $error("Transmit request not gated");
    AST_RX_OFF: assert property (wr && addr == `REG_XFER && wdata[5:4] == 2'b00 |-> ##2 !rxIrq)
        else $error("Receive request not gated");
    AST_ERR_OFF: assert property (wr && addr == `REG_NINTH && wdata[3:0] == 4'h0 |-> ##2 !errIrq)
        else $error("Error request not gated");
    // Main traffic seen.
    C_DEV_START: cover property ($fell(devTx));
    C_REM_START: cover property ($fell(remTx));
    C_RX_REQ: cover property ($rose(rxIrq));
endmodule
